// ### rtl/arc_alarm.v
/*
 one hysteretic threshold alarm for one channel.
 assumes reading and settings are signed and synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "arc_map.vh"
module arc_alarm (
  input wire mclk,
  input wire rst,
  input wire signed [`ARC_VAL_W-1:0] reading,
  input wire signed [`ARC_VAL_W-1:0] threshold,
  input wire signed [`ARC_VAL_W-1:0] hysteresis,
  input wire direction,
  output reg alarm_r
);
  // one extra bit so threshold +/- hysteresis cannot wrap
  wire signed [`ARC_VAL_W:0] upper = threshold + hysteresis;
  wire signed [`ARC_VAL_W:0] lower = threshold - hysteresis;
  wire signed [`ARC_VAL_W:0] rd = {reading[`ARC_VAL_W-1], reading};
  reg alarm_nxt;

  // set/clear bands; between the bands the alarm keeps its state
  always @* begin
    alarm_nxt = alarm_r;
    if (direction == `ARC_DIR_OVER) begin
      if (rd >= upper) alarm_nxt = 1'b1;
      else if (rd <= lower) alarm_nxt = 1'b0;
    end else begin
      if (rd <= lower) alarm_nxt = 1'b1;
      else if (rd >= upper) alarm_nxt = 1'b0;
    end
  end

  // alarm state register
  always @(posedge mclk) begin
    if (rst) alarm_r <= 1'b0;
    else alarm_r <= alarm_nxt;
  end
endmodule
`default_nettype wire

// ### rtl/arc_map.vh
/*
 header of constants for the alarm relay output control block.
 assumes a 250 MHz mclk; delay and hold settings are counts of 0.1 s ticks.
*/
`ifndef ARC_MAP_VH
`define ARC_MAP_VH
`define ARC_CH_NUM 8
`define ARC_OUT_NUM 2
`define ARC_VAL_W 16
`define ARC_TIME_W 16
`define ARC_CLK_MHZ 250
`define ARC_TICK_MS 100
`define ARC_TICK_CYC (`ARC_TICK_MS * 1000 * `ARC_CLK_MHZ)
`define ARC_TICK_CNT_W 25
`define ARC_SRC_NONE 2'h0
`define ARC_SRC_AL1 2'h1
`define ARC_SRC_AL2 2'h2
`define ARC_SRC_BOTH 2'h3
`define ARC_DIR_OVER 1'b0
`define ARC_DIR_UNDER 1'b1
`define ARC_FUNC_OR 1'b0
`define ARC_FUNC_AND 1'b1
`define ARC_POL_NO 1'b0
`define ARC_POL_NC 1'b1
`endif

// ### rtl/arc_relay_ctl.v
/*
 relay output control: per-channel dual alarms, source select, OR/AND combine,
 up/down delay filter, closed/open hold times and N.O./N.C. polarity.
 assumes readings and settings arrive as flat buses synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "arc_map.vh"
module arc_relay_ctl (
  input wire mclk,
  input wire rst,
  input wire [`ARC_CH_NUM*`ARC_VAL_W-1:0] reading,
  input wire [`ARC_CH_NUM*`ARC_VAL_W-1:0] first_threshold,
  input wire [`ARC_CH_NUM*`ARC_VAL_W-1:0] first_hysteresis,
  input wire [`ARC_CH_NUM-1:0] first_alarm_direction,
  input wire [`ARC_CH_NUM*`ARC_VAL_W-1:0] second_threshold,
  input wire [`ARC_CH_NUM*`ARC_VAL_W-1:0] second_hysteresis,
  input wire [`ARC_CH_NUM-1:0] second_alarm_direction,
  input wire [`ARC_OUT_NUM*`ARC_CH_NUM*2-1:0] out_source,
  input wire [`ARC_OUT_NUM-1:0] out_func,
  input wire [`ARC_OUT_NUM-1:0] out_polarity,
  input wire [`ARC_OUT_NUM*`ARC_TIME_W-1:0] close_delay,
  input wire [`ARC_OUT_NUM*`ARC_TIME_W-1:0] open_delay,
  input wire [`ARC_OUT_NUM*`ARC_TIME_W-1:0] closed_hold,
  input wire [`ARC_OUT_NUM*`ARC_TIME_W-1:0] open_hold,
  output reg [`ARC_OUT_NUM-1:0] relay_close_r,
  output reg [`ARC_OUT_NUM-1:0] relay_status_r,
  output reg [`ARC_CH_NUM-1:0] first_alarm_r,
  output reg [`ARC_CH_NUM-1:0] second_alarm_r
);
  localparam [`ARC_TICK_CNT_W-1:0] TICK_LAST = `ARC_TICK_CYC - 1;
  localparam NC = `ARC_CH_NUM;
  localparam NO = `ARC_OUT_NUM;
  localparam TW = `ARC_TIME_W;

  wire [NC-1:0] al1; // raw alarms from the evaluators
  wire [NC-1:0] al2;
  reg [`ARC_TICK_CNT_W-1:0] tick_cnt_r; // 0.1 s divider
  reg tick_r; // one-cycle tick enable
  reg [NO-1:0] func_r; // unfiltered logic function (after polarity-free combine)
  reg [NO-1:0] filt_r; // filtered logic function state
  reg [TW-1:0] dly_cnt_r [0:NO-1]; // up/down delay counters
  reg [TW-1:0] hold_cnt_r [0:NO-1]; // remaining hold ticks
  integer o;

  // channel alarm state for one source selection
  function chan_alarm;
    input [1:0] src;
    input a1;
    input a2;
    begin
      case (src)
        `ARC_SRC_AL1: chan_alarm = a1;
        `ARC_SRC_AL2: chan_alarm = a2;
        `ARC_SRC_BOTH: chan_alarm = a1 & a2;
        default: chan_alarm = 1'b0;
      endcase
    end
  endfunction

  // two evaluators per channel, each with own settings
  genvar c;
  generate
    for (c = 0; c < NC; c = c + 1) begin : g_ch
      arc_alarm u_al1 (
        .mclk(mclk),
        .rst(rst),
        .reading(reading[c*`ARC_VAL_W +: `ARC_VAL_W]),
        .threshold(first_threshold[c*`ARC_VAL_W +: `ARC_VAL_W]),
        .hysteresis(first_hysteresis[c*`ARC_VAL_W +: `ARC_VAL_W]),
        .direction(first_alarm_direction[c]),
        .alarm_r(al1[c])
      );
      arc_alarm u_al2 (
        .mclk(mclk),
        .rst(rst),
        .reading(reading[c*`ARC_VAL_W +: `ARC_VAL_W]),
        .threshold(second_threshold[c*`ARC_VAL_W +: `ARC_VAL_W]),
        .hysteresis(second_hysteresis[c*`ARC_VAL_W +: `ARC_VAL_W]),
        .direction(second_alarm_direction[c]),
        .alarm_r(al2[c])
      );
    end
  endgenerate

  // tick divider; hold and delay only move on the tick
  always @(posedge mclk) begin
    if (rst) begin
      tick_cnt_r <= {`ARC_TICK_CNT_W{1'b0}};
      tick_r <= 1'b0;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= {`ARC_TICK_CNT_W{1'b0}};
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  // combine attached channels; channels with no source are not attached
  reg any_v;
  reg all_v;
  reg att_v;
  reg ca_v;
  reg [NO-1:0] func_nxt; // combined function before the register
  integer k;
  integer m;
  // combinational combine; own loop variables so no other process shares them
  always @* begin
    any_v = 1'b0;
    all_v = 1'b1;
    att_v = 1'b0;
    ca_v = 1'b0;
    func_nxt = {NO{1'b0}};
    for (m = 0; m < NO; m = m + 1) begin
      any_v = 1'b0;
      all_v = 1'b1;
      att_v = 1'b0;
      for (k = 0; k < NC; k = k + 1) begin
        ca_v = chan_alarm(out_source[(m*NC+k)*2 +: 2], al1[k], al2[k]);
        if (out_source[(m*NC+k)*2 +: 2] != `ARC_SRC_NONE) begin
          att_v = 1'b1;
          any_v = any_v | ca_v;
          all_v = all_v & ca_v;
        end
      end
      // AND with nothing attached stays 0
      func_nxt[m] = (out_func[m] == `ARC_FUNC_AND) ? (all_v & att_v) : any_v;
    end
  end

  // function register
  always @(posedge mclk) begin
    if (rst) begin
      func_r <= {NO{1'b0}};
    end else begin
      func_r <= func_nxt;
    end
  end

  // delay filter and hold timer per output; zero delay bypasses the tick so
  // the switch follows the function at once
  always @(posedge mclk) begin
    if (rst) begin
      filt_r <= {NO{1'b0}};
      for (o = 0; o < NO; o = o + 1) begin
        dly_cnt_r[o] <= {TW{1'b0}};
        hold_cnt_r[o] <= {TW{1'b0}};
      end
    end else begin
      for (o = 0; o < NO; o = o + 1) begin
        if (hold_cnt_r[o] != {TW{1'b0}}) begin
          // frozen while holding; only the hold timer runs
          if (tick_r) hold_cnt_r[o] <= hold_cnt_r[o] - 1'b1;
        end else if (!filt_r[o]) begin
          // counting toward the close delay
          if (func_r[o] && dly_cnt_r[o] >= close_delay[o*TW +: TW]) begin
            filt_r[o] <= 1'b1;
            dly_cnt_r[o] <= {TW{1'b0}};
            hold_cnt_r[o] <= closed_hold[o*TW +: TW];
          end else if (tick_r) begin
            if (func_r[o]) dly_cnt_r[o] <= dly_cnt_r[o] + 1'b1;
            else if (dly_cnt_r[o] != {TW{1'b0}}) dly_cnt_r[o] <= dly_cnt_r[o] - 1'b1;
          end
        end else begin
          // in the 1 state the counter counts up toward the open delay before reverting
          if (!func_r[o] && dly_cnt_r[o] >= open_delay[o*TW +: TW]) begin
            filt_r[o] <= 1'b0;
            dly_cnt_r[o] <= {TW{1'b0}};
            hold_cnt_r[o] <= open_hold[o*TW +: TW];
          end else if (tick_r) begin
            if (!func_r[o]) dly_cnt_r[o] <= dly_cnt_r[o] + 1'b1;
            else if (dly_cnt_r[o] != {TW{1'b0}}) dly_cnt_r[o] <= dly_cnt_r[o] - 1'b1;
          end
        end
      end
    end
  end

  // relay drive and status after polarity
  always @(posedge mclk) begin
    if (rst) begin
      relay_close_r <= {NO{1'b0}};
      relay_status_r <= {NO{1'b0}};
      first_alarm_r <= {NC{1'b0}};
      second_alarm_r <= {NC{1'b0}};
    end else begin
      relay_close_r <= filt_r ^ out_polarity;
      relay_status_r <= filt_r ^ out_polarity;
      first_alarm_r <= al1;
      second_alarm_r <= al2;
    end
  end
endmodule
`default_nettype wire

// ### tb/arc_load.sv
/*
 far side: the loads that the two relays switch.
 assumes a load is powered exactly while its relay is closed.
*/
`timescale 1ns/1ps
`default_nettype none
module arc_load (
  input wire [1:0] relay_close_r,
  output wire [1:0] powered
);
  // closed contact feeds the load; bounce is not modelled
  assign powered = relay_close_r;
endmodule
`default_nettype wire

// ### tb/arc_relay_ctl_chk.sv
/*
 assertions on the relay control ports, channel 0 and output 0; status against relay on both outputs.
 assumes the bind below.
*/
`timescale 1ns/1ps
`default_nettype none
module arc_relay_ctl_chk (
  input wire mclk,
  input wire rst,
  input wire [127:0] reading,
  input wire [127:0] first_threshold,
  input wire [127:0] first_hysteresis,
  input wire [127:0] second_threshold,
  input wire [127:0] second_hysteresis,
  input wire [7:0] first_alarm_direction,
  input wire [7:0] second_alarm_direction,
  input wire [31:0] out_source,
  input wire [1:0] out_func,
  input wire [1:0] out_polarity,
  input wire [31:0] close_delay,
  input wire [31:0] open_delay,
  input wire [31:0] closed_hold,
  input wire [31:0] open_hold,
  input wire [1:0] relay_close_r,
  input wire [1:0] relay_status_r,
  input wire [7:0] first_alarm_r,
  input wire [7:0] second_alarm_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // band edges one bit wider so a sum never wraps
  wire signed [16:0] r = $signed(reading[15:0]);
  wire signed [16:0] hi1 = $signed(first_threshold[15:0]) + $signed(first_hysteresis[15:0]);
  wire signed [16:0] lo1 = $signed(first_threshold[15:0]) - $signed(first_hysteresis[15:0]);
  wire signed [16:0] hi2 = $signed(second_threshold[15:0]) + $signed(second_hysteresis[15:0]);
  wire signed [16:0] lo2 = $signed(second_threshold[15:0]) - $signed(second_hysteresis[15:0]);
  // output 0 fed by channel 0 alarm 1 alone, no delay and no hold
  wire c0 = out_source[15:0] == 16'h0001 && !out_func[0]
    && ~|{close_delay, open_delay, closed_hold, open_hold};
  // setting must stay put over the filter and polarity stages
  sequence held_s(c, a);
    $past(c) && c && a ##1 c;
  endsequence
  property rel_p(c, a, y);
    held_s(c, a) |-> ##1 y;
  endproperty
  status_mirror_a: assert property (relay_status_r == relay_close_r)
    else $error("status differs from relay");
  over_set_a: assert property (!first_alarm_direction[0] && r >= hi1 |-> ##2 first_alarm_r[0])
    else $error("over alarm not set");
  over_clear_a: assert property (!first_alarm_direction[0] && r <= lo1 |-> ##2 !first_alarm_r[0])
    else $error("over alarm not cleared");
  under_set_a: assert property (second_alarm_direction[0] && r <= lo2 |-> ##2 second_alarm_r[0])
    else $error("under alarm not set");
  under_clear_a: assert property (second_alarm_direction[0] && r >= hi2 |-> ##2 !second_alarm_r[0])
    else $error("under alarm not cleared");
  no_close_a: assert property (rel_p(c0 && !out_polarity[0], first_alarm_r[0], relay_close_r[0]))
    else $error("relay did not close");
  no_open_a: assert property (rel_p(c0 && !out_polarity[0], !first_alarm_r[0], !relay_close_r[0]))
    else $error("relay did not open");
  nc_open_a: assert property (rel_p(c0 && out_polarity[0], first_alarm_r[0], !relay_close_r[0]))
    else $error("inverted relay did not open");
endmodule
bind arc_relay_ctl arc_relay_ctl_chk chk (.*);
`default_nettype wire

// ### tb/tb.sv
/*
 self-checking bench for the relay control block.
 assumes zero delays and holds: one 0.1 s tick is 25e6 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam [175:0] LST = {16'hFFFB, 16'h00CD, 16'h00FA, 16'h00D2, 16'h00BE, 16'h005A,
    16'h005B, 16'h0096, 16'h006E, 16'h006D, 16'h0000};
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg [15:0] v = 16'h0000;
  reg [127:0] t1 = {{7{16'h00C8}}, 16'h0064};
  reg [127:0] t2 = {8{16'h00C8}};
  reg [127:0] h = {8{16'h000A}};
  reg [31:0] src = 32'h00070001;
  reg [31:0] tz = 32'h00000000;
  reg [1:0] fn = 2'h0;
  reg [1:0] pol = 2'h2;
  reg e1, e2, e3, r0;
  integer mismatches = 0, checked = 0, i, p;
  wire [1:0] rc, rs, ld;
  wire [7:0] fa, sa;
  always #2 mclk = ~mclk;
  arc_relay_ctl dut (.mclk(mclk), .rst(rst), .reading({8{v}}), .first_threshold(t1),
    .first_hysteresis(h), .first_alarm_direction(8'hFE), .second_threshold(t2),
    .second_hysteresis(h), .second_alarm_direction(8'hFF), .out_source(src), .out_func(fn),
    .out_polarity(pol), .close_delay(tz), .open_delay(tz), .closed_hold(tz), .open_hold(tz),
    .relay_close_r(rc), .relay_status_r(rs), .first_alarm_r(fa), .second_alarm_r(sa));
  arc_load load (.relay_close_r(rc), .powered(ld));
  // expected alarm: d=1 under, d=0 over, band of 10
  function hy(input c, input d, input integer x, input integer t);
    hy = (d ? x <= t - 10 : x >= t + 10) ? 1'b1 : (d ? x >= t + 10 : x <= t - 10) ? 1'b0 : c;
  endfunction
  task chk(input [7:0] s, input [7:0] e);
    begin
      checked = checked + 1;
      if (s !== e) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask
  // phases: alarm 1 alone, alarm 2 alone with output 1 on AND, output 0 inverted polarity
  initial begin
    {e1, e2, e3} = 3'b000;
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    for (p = 0; p < 3; p = p + 1) begin
      src[15:0] = (p == 1) ? 16'h0002 : 16'h0001;
      fn = (p == 1) ? 2'h2 : 2'h0;
      pol = (p == 2) ? 2'h3 : 2'h2;
      for (i = 0; i < 11; i = i + 1) begin
        v = LST[i*16 +: 16];
        e1 = hy(e1, 1'b0, $signed(v), 100);
        e2 = hy(e2, 1'b1, $signed(v), 200);
        e3 = hy(e3, 1'b1, $signed(v), 200);
        r0 = ((p == 1) ? e2 : e1) ^ pol[0];
        repeat (5) @(posedge mclk);
        #1;
        chk({5'h00, fa[1:0], sa[0]}, {5'h00, e3, e1, e2});
        chk({5'h00, ld[0], rs[0], rc[0]}, {5'h00, {3{r0}}});
        chk({5'h00, ld[1], rs[1], rc[1]}, {5'h00, {3{~(fn[1] ? e1 & e2 & e3 : (e1 & e2) | e3)}}});
      end
      $display("test %0d done", p);
    end
    complete_run;
  end
endmodule
`default_nettype wire
